// ===== rtl/scp_top.sv
// serial configuration port: request/status/done handshake, active
// serial flash reader, passive serial receiver and initialization phase
// assumes open-drain pins resolved outside; pins are asynchronous
`timescale 1ns/1ps
module scp_top #(
  parameter int unsigned POR_CYC       = scp_pkg::CYC_POR,
  parameter int unsigned STATUS_CYC    = scp_pkg::CYC_STATUS_MIN,
  parameter int unsigned INIT_OSC_CYC  = scp_pkg::CYC_CD2UM_MIN,
  parameter int unsigned UCLK_INIT_CYC = scp_pkg::UCLK_INIT_CYCLES,
  parameter int unsigned CONFIG_SHIFT_CLOCK_INIT_CYC = scp_pkg::UCLK_INIT_CYCLES,
  parameter int          CFG_BITS      = scp_pkg::CFG_BITS_DEF,
  parameter int          ACT_RANGE     = 0,
  parameter bit          MULTI_DEVICE  = 1'b0,
  parameter logic [7:0]  FLASH_CMD     = scp_pkg::FLASH_READ_CMD
) (
  input  wire logic       core_clk_i,              // core clock
  input  wire logic       rst_i,                   // sync reset
  input  wire logic       config_shift_clock_i,    // shift clock pin in
  output logic            config_shift_clock_o,    // shift clock pin out
  output logic            config_shift_clock_oe_o, // shift clock drive
  input  wire logic       user_init_clock_i,       // user init clock
  input  wire logic [1:0] mode_sel_i,              // scheme strap
  input  wire logic       config_req_n_i,          // config request
  input  wire logic       status_n_i,              // status pin level
  output logic            status_n_o,              // status pin out
  output logic            status_n_oe_o,           // status pull low
  input  wire logic       done_i,                  // done pin level
  output logic            done_o,                  // done pin out
  output logic            done_oe_o,               // done pull low
  output logic            init_done_o,             // init-done pin out
  output logic            init_done_oe_o,          // init-done pull low
  input  wire logic       serial_config_in_i,      // passive data
  output logic            flash_select_n_o,        // flash select
  output logic            flash_command_out_o,     // flash command
  input  wire logic [3:0] flash_data_lines_i,      // flash data
  output logic            user_mode_o              // user mode reached
);
  import scp_pkg::*;

  localparam int ACT_EFF =
    (MULTI_DEVICE && ACT_RANGE == AS_RANGES - 1) ? AS_CHAIN_MAX_RANGE
                                                 : ACT_RANGE;
  localparam int DIV  = as_div(ACT_EFF);
  localparam int HALF = DIV / 2;
  localparam int DW   = $clog2(DIV + 1);
  localparam int BW   = $clog2(CFG_BITS + QUAD_W + 1);
  localparam int CLW  = $clog2(CMD_BITS + 2);
  localparam int UW   = $clog2(UCLK_INIT_CYC + 1);

  if (CFG_BITS % QUAD_W != 0 || CFG_BITS <= OPT_BITS ||
      ACT_RANGE < 0 || ACT_RANGE >= AS_RANGES ||
      POR_CYC < 1 || STATUS_CYC < 1 || INIT_OSC_CYC < 1 ||
      POR_CYC >= (1 << TIMER_W) || STATUS_CYC >= (1 << TIMER_W) ||
      INIT_OSC_CYC >= (1 << TIMER_W) || UCLK_INIT_CYC < 1 ||
      CONFIG_SHIFT_CLOCK_INIT_CYC < 1) begin : g_bad_param
    $error("scp_top: unsupported parameter value");
  end

  function automatic logic t_hit(input logic [TIMER_W-1:0] t,
                                 input int unsigned n);
    return t >= TIMER_W'(n);
  endfunction

  scp_link_if lk ();

  // synchronized pins and link levels
  logic [12:0] sync_d;
  logic [12:0] sync_q;
  logic        req_n_s;
  logic        status_s;
  logic [3:0]  data_s;
  logic [1:0]  mode_s;
  logic        optv_s;
  logic        allrx_s;
  logic        edges_s;
  logic        dclkd_s;
  logic        udone_s;

  // control state
  scp_state_e          state_ff;
  scp_state_e          nxt_state;
  logic [TIMER_W-1:0]  timer_ff;
  logic [TIMER_W-1:0]  nxt_timer;
  scp_mode_e           mode_ff;
  logic                seen_ff;
  logic [OPT_BITS-1:0] opt_ff;
  logic                opt_loaded_ff;

  // active serial engine
  logic [DW-1:0]       div_ff;
  logic                sclk_ff;
  logic [CMD_BITS-1:0] cmd_sr_ff;
  logic [CLW-1:0]      cmd_left_ff;
  logic [BW-1:0]       bits_ff;
  logic                act_all_ff;
  logic [OPT_BITS-1:0] opt_sr_ff;
  logic                cmd_out_ff;

  // pin drive and crossings
  logic                status_low_ff;
  logic                done_low_ff;
  logic                init_low_ff;
  logic                user_ff;
  logic                uen_ff;
  logic                config_shift_clock_en_ff;
  logic                clr_ff;
  logic                clk_oe_ff;
  logic                sel_n_ff;

  // user init clock domain
  logic                uen_s;
  logic [UW-1:0]       ucnt_ff;
  logic                udone_ff;

  assign sync_d = {config_req_n_i, status_n_i, flash_data_lines_i,
                   mode_sel_i, lk.opt_valid, lk.all_rx, lk.edges_ok,
                   lk.config_shift_clock_done, udone_ff};
  assign {req_n_s, status_s, data_s, mode_s, optv_s, allrx_s, edges_s,
          dclkd_s, udone_s} = sync_q;

  scp_sync #(.W(13)) u_core_sync (
    .clk_i (core_clk_i),
    .d_i   (sync_d),
    .q_o   (sync_q)
  );

  scp_sync #(.W(1)) u_uclk_sync (
    .clk_i (user_init_clock_i),
    .d_i   (uen_ff),
    .q_o   (uen_s)
  );

  scp_pasv_rx #(
    .CFG_BITS (CFG_BITS),
    .INIT_CYC (int'(CONFIG_SHIFT_CLOCK_INIT_CYC))
  ) u_rx (
    .link_clk_i (config_shift_clock_i),
    .lk         (lk)
  );

  assign lk.clr          = clr_ff;
  assign lk.serial_in    = serial_config_in_i;
  assign lk.config_shift_clock_init_en = config_shift_clock_en_ff;

  // decode
  wire in_rst_w   = (state_ff == ST_POR) || (state_ff == ST_RESET);
  wire act_w      = (mode_ff != MODE_PASSIVE);
  wire quad_w     = (mode_ff == MODE_ACTIVE_X4);
  wire act_run_w  = (state_ff == ST_LOAD) && act_w && seen_ff && !act_all_ff;
  wire div_end_w  = (div_ff == DW'(DIV - 1));
  wire fall_w     = act_run_w && div_end_w;
  wire cap_w      = fall_w && (cmd_left_ff == '0);
  wire launch_w   = fall_w && (cmd_left_ff != '0);
  wire all_rx_w   = act_w ? act_all_ff : allrx_s;
  wire enter_ld_w = (nxt_state == ST_LOAD) && (state_ff != ST_LOAD);
  wire [DW-1:0] div_nxt_w = div_end_w ? '0 : div_ff + DW'(1);
  wire [BW-1:0] step_w    = quad_w ? BW'(QUAD_W) : BW'(1);
  wire [BW-1:0] bits_nxt_w = bits_ff + step_w;
  wire [OPT_BITS-1:0] opt_sh_w = quad_w ?
    {opt_sr_ff[OPT_BITS-QUAD_W-1:0], data_s} :
    {opt_sr_ff[OPT_BITS-2:0], data_s[0]};
  wire [OPT_SRC_W-1:0] src_raw_w = opt_ff[OPT_SRC_LSB +: OPT_SRC_W];

  // shift clock source only in passive schemes
  scp_src_e eff_src;
  assign eff_src = (src_raw_w == SRC_USER) ? SRC_USER :
                   (src_raw_w == SRC_SHIFT && !act_w) ? SRC_SHIFT :
                   SRC_OSC;
  wire init_ok_w = (eff_src == SRC_USER)  ? udone_s :
                   (eff_src == SRC_SHIFT) ? dclkd_s :
                   t_hit(timer_ff, INIT_OSC_CYC - 1);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_POR: begin
        if (t_hit(timer_ff, POR_CYC - 1) && req_n_s)
          nxt_state = ST_LOAD;
      end
      ST_RESET: begin
        if (t_hit(timer_ff, STATUS_CYC - 1) && req_n_s)
          nxt_state = ST_LOAD;
      end
      ST_LOAD: begin
        if (seen_ff && !status_s)
          nxt_state = ST_RESET;
        else if (all_rx_w)
          nxt_state = ST_EDGES;
      end
      ST_EDGES: begin
        if (act_w || edges_s)
          nxt_state = ST_INIT;
      end
      ST_INIT: begin
        if (init_ok_w)
          nxt_state = ST_USER;
      end
      ST_USER: begin
        nxt_state = ST_USER;
      end
      default: begin
        nxt_state = ST_RESET;
      end
    endcase
    if (!req_n_s && state_ff != ST_POR)
      nxt_state = ST_RESET;
  end

  always_comb begin
    if (nxt_state != state_ff)
      nxt_timer = '0;
    else if (timer_ff == '1)
      nxt_timer = timer_ff;
    else
      nxt_timer = timer_ff + TIMER_W'(1);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_ff <= ST_POR;
      timer_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mode_ff <= MODE_PASSIVE;
      seen_ff <= 1'b0;
    end else if (enter_ld_w) begin
      mode_ff <= (mode_s == 2'h3) ? MODE_PASSIVE : scp_mode_e'(mode_s);
      seen_ff <= 1'b0;
    end else if (state_ff == ST_LOAD && status_s) begin
      seen_ff <= 1'b1;
    end
  end

  // option byte from the first bitstream bits
  always_ff @(posedge core_clk_i) begin
    if (rst_i || nxt_state == ST_RESET) begin
      opt_ff        <= '0;
      opt_loaded_ff <= 1'b0;
    end else if (!opt_loaded_ff) begin
      if (act_w && cap_w && bits_nxt_w >= BW'(OPT_BITS)) begin
        opt_ff        <= opt_sh_w;
        opt_loaded_ff <= 1'b1;
      end else if (!act_w && state_ff == ST_LOAD && optv_s) begin
        opt_ff        <= lk.opt_byte;
        opt_loaded_ff <= 1'b1;
      end
    end
  end

  // active serial: shift clock divided from the core clock
  always_ff @(posedge core_clk_i) begin
    if (rst_i || enter_ld_w) begin
      div_ff      <= '0;
      sclk_ff     <= 1'b0;
      cmd_sr_ff   <= {FLASH_CMD, {FLASH_ADDR_BITS{1'b0}}};
      cmd_left_ff <= CLW'(CMD_BITS + 1);
      bits_ff     <= '0;
      act_all_ff  <= 1'b0;
      opt_sr_ff   <= '0;
      cmd_out_ff  <= 1'b0;
    end else if (act_run_w) begin
      div_ff  <= div_nxt_w;
      sclk_ff <= (div_nxt_w >= DW'(HALF));
      if (launch_w) begin
        cmd_out_ff  <= cmd_sr_ff[CMD_BITS-1];
        cmd_sr_ff   <= {cmd_sr_ff[CMD_BITS-2:0], 1'b0};
        cmd_left_ff <= cmd_left_ff - CLW'(1);
      end
      if (cap_w) begin
        bits_ff <= bits_nxt_w;
        if (bits_ff < BW'(OPT_BITS))
          opt_sr_ff <= opt_sh_w;
        if (bits_nxt_w >= BW'(CFG_BITS))
          act_all_ff <= 1'b1;
      end
    end else begin
      sclk_ff <= 1'b0;
    end
  end

  wire nxt_rst_w  = (nxt_state == ST_POR) || (nxt_state == ST_RESET);
  wire nxt_init_w = (nxt_state == ST_INIT) || (nxt_state == ST_USER);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      status_low_ff <= 1'b1;
      done_low_ff   <= 1'b1;
      init_low_ff   <= 1'b0;
      user_ff       <= 1'b0;
      uen_ff        <= 1'b0;
      config_shift_clock_en_ff    <= 1'b0;
      clr_ff        <= 1'b1;
      clk_oe_ff     <= 1'b0;
      sel_n_ff      <= 1'b1;
    end else begin
      status_low_ff <= nxt_rst_w;
      done_low_ff   <= nxt_rst_w || (nxt_state == ST_LOAD);
      init_low_ff   <= opt_loaded_ff && opt_ff[OPT_INIT_DONE_EN] &&
                       !nxt_rst_w && (nxt_state != ST_USER);
      user_ff       <= (nxt_state == ST_USER);
      uen_ff        <= nxt_init_w && (eff_src == SRC_USER) &&
                       (uen_ff || t_hit(timer_ff, CYC_CD2CU));
      config_shift_clock_en_ff    <= !nxt_rst_w && opt_loaded_ff &&
                       (eff_src == SRC_SHIFT);
      clr_ff        <= nxt_rst_w;
      clk_oe_ff     <= act_w && !in_rst_w;
      sel_n_ff      <= !act_run_w;
    end
  end

  // user init clock counts its cycles once enabled
  always_ff @(posedge user_init_clock_i) begin
    if (!uen_s) begin
      ucnt_ff  <= '0;
      udone_ff <= 1'b0;
    end else if (!udone_ff) begin
      ucnt_ff <= ucnt_ff + UW'(1);
      if (ucnt_ff == UW'(UCLK_INIT_CYC - 1))
        udone_ff <= 1'b1;
    end
  end

  assign config_shift_clock_o    = sclk_ff;
  assign config_shift_clock_oe_o = clk_oe_ff;
  assign status_n_o              = 1'b0;
  assign status_n_oe_o           = status_low_ff;
  assign done_o                  = 1'b0;
  assign done_oe_o               = done_low_ff;
  assign init_done_o             = 1'b0;
  assign init_done_oe_o          = init_low_ff;
  assign flash_select_n_o        = sel_n_ff;
  assign flash_command_out_o     = cmd_out_ff;
  assign user_mode_o             = user_ff;
endmodule

// ===== shared/scp_pkg.sv
// constants, types and helpers of the serial configuration port
// assumes a 250 MHz core clock; all CYC_ counts below derive from that rate
package scp_pkg;

  localparam int CORE_CLK_MHZ = 250;
  localparam int CORE_CLK_KHZ = CORE_CLK_MHZ * 1000;

  // request falling to status/done low, longest
  localparam int T_CF2X_MAX_NS = 600;
  localparam int CYC_CF2X_MAX  = (T_CF2X_MAX_NS * CORE_CLK_MHZ) / 1000;
  localparam int T_CFG_MIN_US  = 2;

  // status low pulse, least and longest
  localparam int T_STATUS_MIN_US = 268;
  localparam int T_STATUS_MAX_US = 1506;
  localparam int CYC_STATUS_MIN  = T_STATUS_MIN_US * CORE_CLK_MHZ;
  localparam int T_POR_US        = T_STATUS_MIN_US;
  localparam int CYC_POR         = T_POR_US * CORE_CLK_MHZ;

  // done high to user mode on the internal oscillator
  localparam int T_CD2UM_MIN_US = 175;
  localparam int T_CD2UM_MAX_US = 437;
  localparam int CYC_CD2UM_MIN  = T_CD2UM_MIN_US * CORE_CLK_MHZ;

  // done high to user init clock enabled: four longest shift clock periods
  localparam int T_SHIFT_MAX_PERIOD_NS = 8;
  localparam int CD2CU_PERIODS         = 4;
  localparam int CYC_CD2CU =
    (CD2CU_PERIODS * T_SHIFT_MAX_PERIOD_NS * CORE_CLK_MHZ + 999) / 1000;

  localparam int UCLK_INIT_CYCLES = 8576;
  localparam int EDGES_AFTER_DONE = 2;

  // active serial clock ranges, upper bound of each in kHz
  localparam int AS_RANGES          = 4;
  localparam int AS_CHAIN_MAX_RANGE = 2;
  localparam int AS_RANGE_KHZ [AS_RANGES] = '{12500, 25000, 50000, 100000};

  // bitstream layout: option byte first, msb first
  localparam int CFG_BITS_DEF     = 1024;
  localparam int OPT_BITS         = 8;
  localparam int OPT_INIT_DONE_EN = 0;
  localparam int OPT_SRC_LSB      = 1;
  localparam int OPT_SRC_W        = 2;
  localparam int QUAD_W           = 4;

  // flash read command and address
  localparam logic [7:0] FLASH_READ_CMD = 8'h03;
  localparam int FLASH_ADDR_BITS = 24;
  localparam int CMD_BITS        = 32;

  localparam int TIMER_W = 17;

  typedef enum logic [1:0] {
    SRC_OSC   = 2'h0,
    SRC_USER  = 2'h1,
    SRC_SHIFT = 2'h2
  } scp_src_e;

  typedef enum logic [1:0] {
    MODE_ACTIVE_X1 = 2'h0,
    MODE_ACTIVE_X4 = 2'h1,
    MODE_PASSIVE   = 2'h2
  } scp_mode_e;

  typedef enum logic [2:0] {
    ST_POR   = 3'h0,
    ST_RESET = 3'h1,
    ST_LOAD  = 3'h3,
    ST_EDGES = 3'h2,
    ST_INIT  = 3'h6,
    ST_USER  = 3'h7
  } scp_state_e;

  // core cycles per active serial clock period, rounded up
  function automatic int as_div(input int rng);
    return (CORE_CLK_KHZ + AS_RANGE_KHZ[rng] - 1) / AS_RANGE_KHZ[rng];
  endfunction

endpackage

// ===== shared/scp_link_if.sv
// signals between the core-side control and the shift-clock receiver
// assumes clr is a core flop and link-side outputs are link flops, edges_ok a decode of one
`timescale 1ns/1ps
interface scp_link_if;
  logic       clr;
  logic       serial_in;
  logic       config_shift_clock_init_en;
  logic [7:0] opt_byte;
  logic       opt_valid;
  logic       all_rx;
  logic       edges_ok;
  logic       config_shift_clock_done;

  modport core (output clr, serial_in, config_shift_clock_init_en,
                input  opt_byte, opt_valid, all_rx, edges_ok, config_shift_clock_done);
  modport link (input  clr, serial_in, config_shift_clock_init_en,
                output opt_byte, opt_valid, all_rx, edges_ok, config_shift_clock_done);
endinterface

// ===== rtl/scp_sync.sv
// two flip-flop level synchronizer
// assumes each bit is a slow level; no bus coherence across bits
`timescale 1ns/1ps
module scp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i, // destination clock
  input  wire logic [W-1:0] d_i,   // asynchronous levels
  output logic      [W-1:0] q_o    // synchronized levels
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk_i) begin
    meta_ff <= d_i;
    q_ff    <= meta_ff;
  end

  assign q_o = q_ff;
endmodule

// ===== rtl/scp_pasv_rx.sv
// passive serial receiver, runs on the host-driven shift clock
// assumes lk.clr is released well before the first rising shift edge
`timescale 1ns/1ps
module scp_pasv_rx #(
  parameter int CFG_BITS = scp_pkg::CFG_BITS_DEF,
  parameter int INIT_CYC = scp_pkg::UCLK_INIT_CYCLES
) (
  input wire logic link_clk_i, // shift clock from the host
  scp_link_if.link lk          // control and status to the core
);
  import scp_pkg::*;

  localparam int CW = $clog2(CFG_BITS + 1);
  localparam int IW = $clog2(INIT_CYC + 1);

  logic [CW-1:0]       cnt_ff;
  logic [OPT_BITS-1:0] opt_ff;
  logic                valid_ff;
  logic                all_ff;
  logic [1:0]          edge_ff;
  logic [IW-1:0]       icnt_ff;
  logic                idone_ff;
  logic                en_meta_ff;
  logic                en_ff;
  wire                 edges_ok_w;

  assign edges_ok_w = (edge_ff == 2'(EDGES_AFTER_DONE));

  // data sampled on rising edges; clear released long before first edge
  always_ff @(posedge link_clk_i or posedge lk.clr) begin
    if (lk.clr) begin
      cnt_ff   <= '0;
      opt_ff   <= '0;
      valid_ff <= 1'b0;
      all_ff   <= 1'b0;
    end else if (!all_ff) begin
      cnt_ff <= cnt_ff + CW'(1);
      if (!valid_ff)
        opt_ff <= {opt_ff[OPT_BITS-2:0], lk.serial_in};
      if (cnt_ff == CW'(OPT_BITS - 1))
        valid_ff <= 1'b1;
      if (cnt_ff == CW'(CFG_BITS - 1))
        all_ff <= 1'b1;
    end
  end

  // falling edges after done, then optional init on the shift clock
  always_ff @(negedge link_clk_i or posedge lk.clr) begin
    if (lk.clr) begin
      edge_ff    <= 2'h0;
      icnt_ff    <= '0;
      idone_ff   <= 1'b0;
      en_meta_ff <= 1'b0;
      en_ff      <= 1'b0;
    end else begin
      // core-side enable resynchronized on falling shift edges
      en_meta_ff <= lk.config_shift_clock_init_en;
      en_ff      <= en_meta_ff;
      if (all_ff && !edges_ok_w) begin
        edge_ff <= edge_ff + 2'h1;
      end else if (edges_ok_w && en_ff && !idone_ff) begin
        icnt_ff <= icnt_ff + IW'(1);
        if (icnt_ff == IW'(INIT_CYC - 1))
          idone_ff <= 1'b1;
      end
    end
  end

  assign lk.opt_byte  = opt_ff;
  assign lk.opt_valid = valid_ff;
  assign lk.all_rx    = all_ff;
  assign lk.edges_ok  = edges_ok_w;
  assign lk.config_shift_clock_done = idone_ff;
endmodule

// ===== dv/scp_top_monitor.sv
// timing checks on the pins of the configuration port
// assumes the strap changes only in the reset state; sync active-high reset
`timescale 1ns/1ps
module scp_top_monitor #(
  parameter int unsigned POR_CYC      = 1,
  parameter int unsigned STATUS_CYC   = 1,
  parameter int unsigned INIT_OSC_CYC = 1
) (
  input wire logic       core_clk_i,              // core clock
  input wire logic       rst_i,                   // sync reset
  input wire logic [1:0] mode_sel_i,              // scheme strap
  input wire logic       config_req_n_i,          // config request
  input wire logic       status_n_oe_o,           // status pull low
  input wire logic       done_oe_o,               // done pull low
  input wire logic       init_done_oe_o,          // init-done pull low
  input wire logic       flash_select_n_o,        // flash select
  input wire logic       config_shift_clock_oe_o, // shift clock drive
  input wire logic       user_mode_o              // user mode
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] st_ff;
  logic [15:0] hold_ff;
  logic [15:0] done_ff;
  wire logic [15:0] nxt_st   = status_n_oe_o ? st_ff + 16'h1 : 16'h0;
  wire logic        hold_c   = status_n_oe_o && config_req_n_i;
  wire logic [15:0] nxt_hold = hold_c ? hold_ff + 16'h1 : 16'h0;
  wire logic [15:0] nxt_done = done_oe_o ? 16'h0 : done_ff + 16'h1;
  always_ff @(posedge core_clk_i) begin
    st_ff   <= rst_i ? 16'h0 : nxt_st;
    hold_ff <= rst_i ? 16'h0 : nxt_hold;
    done_ff <= rst_i ? 16'h0 : nxt_done;
  end
  a_done_pull_req: assert property (
    $fell(config_req_n_i) |-> ##[1:150] done_oe_o)
    else $error("done not pulled low after request");
  a_status_pull_req: assert property (
    $fell(config_req_n_i) |-> ##[1:150] status_n_oe_o)
    else $error("status not pulled low after request");
  a_status_min_len: assert property (
    $fell(status_n_oe_o) |-> st_ff >= STATUS_CYC - 2)
    else $error("status low pulse too short");
  a_status_rel_bound: assert property (
    hold_ff <= POR_CYC + 8)
    else $error("status held after request high");
  a_done_rel_load: assert property (
    $fell(done_oe_o) |-> !status_n_oe_o && !user_mode_o)
    else $error("done released outside loading");
  a_user_lines_high: assert property (
    $rose(user_mode_o) |-> !status_n_oe_o && !done_oe_o)
    else $error("user mode with a line held low");
  a_init_min_wait: assert property (
    $rose(user_mode_o) |-> done_ff >= INIT_OSC_CYC)
    else $error("user mode too soon after done");
  a_init_done_hold: assert property (
    init_done_oe_o |-> !user_mode_o)
    else $error("init-done held low in user mode");
  a_done_with_status: assert property (
    status_n_oe_o |-> done_oe_o)
    else $error("done free while status held");
  a_passive_no_drive: assert property (
    mode_sel_i[1] |-> flash_select_n_o && !config_shift_clock_oe_o)
    else $error("flash pins driven in passive mode");
  c_reconfig: cover property ($fell(config_req_n_i) ##[1:150] status_n_oe_o);
  c_done: cover property ($fell(done_oe_o));
  c_user: cover property ($rose(user_mode_o));
  c_active: cover property ($fell(flash_select_n_o));
endmodule

// ===== dv/scp_host_model.sv
// passive serial host: shift clock and data, option byte first
// assumes the bench resolves the status wire with a pull-up
`timescale 1ns/1ps
module scp_host_model #(
  parameter int CFG_BITS = 64
) (
  input  wire logic status_n_i,  // resolved status level
  output logic      shift_clk_o, // shift clock to the device
  output logic      data_o       // serial data to the device
);
  initial begin
    shift_clk_o = 1'b0;
    data_o      = 1'b0;
  end
  task automatic load(input logic [7:0] opt, input int nfall);
    logic [CFG_BITS-1:0] bits;
    int i;
    for (i = 0; i < CFG_BITS; i++) bits[i] = i[0] ^ i[3];
    bits[CFG_BITS-1 -: 8] = opt;
    i = 0;
    while (status_n_i !== 1'b1 && i < 5000) begin
      #4 i++;
    end
    #2000;
    for (i = CFG_BITS - 1; i >= 0; i--) begin
      data_o = bits[i];
      #24 shift_clk_o = 1'b1;
      #24 shift_clk_o = 1'b0;
    end
    data_o = ~data_o;
    repeat (nfall) begin
      #24 shift_clk_o = 1'b1;
      #24 shift_clk_o = 1'b0;
    end
  endtask
endmodule

// ===== dv/tb.sv
// top bench: passive loads with each init source, an active x4 load,
// and reconfiguration
// assumes pull-ups on status and done; user init clock runs freely
`timescale 1ns/1ps
module tb;
  localparam int POR_C = 60;
  localparam int ST_C  = 50;
  localparam int OSC_C = 50;
  logic core_clk_i, rst_i, user_init_clock_i, config_req_n_i;
  logic config_shift_clock_i, serial_config_in_i;
  logic status_n_oe_o, done_oe_o, init_done_oe_o, user_mode_o;
  logic config_shift_clock_oe_o, flash_select_n_o, config_shift_clock_o;
  logic flash_command_out_o;
  logic [1:0] mode_sel_i;
  // nibble 3 packs to option 8'h33 in x4: init-done on, user clock init
  wire logic [3:0] flash_data_lines_i = 4'h3;
  wire logic       status_n_i         = ~status_n_oe_o;
  wire logic       done_i             = ~done_oe_o;
  int err_count, total_checks;
  scp_top #(.POR_CYC(POR_C), .STATUS_CYC(ST_C), .INIT_OSC_CYC(OSC_C),
    .UCLK_INIT_CYC(16), .CONFIG_SHIFT_CLOCK_INIT_CYC(16), .CFG_BITS(64)) DUT (
    .core_clk_i, .rst_i, .config_shift_clock_i,
    .config_shift_clock_o, .config_shift_clock_oe_o,
    .user_init_clock_i, .mode_sel_i, .config_req_n_i, .status_n_i,
    .status_n_o(), .status_n_oe_o, .done_i, .done_o(), .done_oe_o,
    .init_done_o(), .init_done_oe_o, .serial_config_in_i,
    .flash_select_n_o, .flash_command_out_o, .flash_data_lines_i,
    .user_mode_o);
  scp_host_model #(.CFG_BITS(64)) HOST (.status_n_i,
    .shift_clk_o(config_shift_clock_i), .data_o(serial_config_in_i));
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  initial begin
    user_init_clock_i = 1'b0;
    forever #20 user_init_clock_i = ~user_init_clock_i;
  end
  task automatic tally_and_finish();
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", w, e, g);
    end
  endtask
  task automatic rng(input string w, input int lo, hi, n);
    total_checks++;
    if (n < lo || n > hi) begin
      err_count++;
      $display("BAD %s exp %0d..%0d got %0d", w, lo, hi, n);
    end
  endtask
  // 0 status pull, 1 done pull, 2 user mode
  task automatic wait_sig(input int s, input logic v, input int lim,
                          output int n);
    logic q;
    n = 0;
    do begin
      @(posedge core_clk_i);
      #1 n++;
      q = s == 0 ? status_n_oe_o : s == 1 ? done_oe_o : user_mode_o;
      if (n > lim) begin
        err_count++;
        $display("BAD wait%0d exp %b got %b", s, v, q);
        tally_and_finish();
      end
    end while (q !== v);
  endtask
  task automatic sc_power_up();
    int n;
    chk("status_por", 1'b1, status_n_oe_o);
    chk("done_por", 1'b1, done_oe_o);
    wait_sig(0, 1'b0, 2000, n);
    rng("por_len", POR_C - 3, POR_C + 5, n);
    chk("done_load", 1'b1, done_oe_o);
  endtask
  task automatic sc_load(input logic [7:0] opt, input int nf, lo, hi);
    int n;
    fork
      HOST.load(opt, nf);
    join_none
    repeat (800) @(posedge core_clk_i);
    #1 chk("done_mid", 1'b1, done_oe_o);
    chk("init_done_pull", opt[0], init_done_oe_o);
    wait_sig(1, 1'b0, 2000, n);
    wait_sig(2, 1'b1, 3000, n);
    rng("init_time", lo, hi, n);
    @(posedge core_clk_i);
    #1 chk("init_done_free", 1'b0, init_done_oe_o);
    chk("status_user", 1'b0, status_n_oe_o);
  endtask
  task automatic sc_reconfig(input logic [1:0] m);
    int n;
    @(posedge core_clk_i);
    #1 config_req_n_i = 1'b0;
    wait_sig(0, 1'b1, 150, n);
    chk("done_pull", 1'b1, done_oe_o);
    chk("user_left", 1'b0, user_mode_o);
    repeat (600) @(posedge core_clk_i);
    #1 config_req_n_i = 1'b1;
    mode_sel_i = m;
    wait_sig(0, 1'b0, 2000, n);
    rng("status_rel", 1, ST_C + 10, n);
    chk("done_hold", 1'b1, done_oe_o);
  endtask
  // command bits sampled on rising shift edges; rise 1 precedes launch
  task automatic sc_active();
    logic [7:0] cmd;
    logic       p;
    int         n, k;
    p = 1'b1;
    k = 0;
    for (n = 0; n < 2000 && k < 9; n++) begin
      @(posedge core_clk_i);
      #1 if (config_shift_clock_o && !p) begin
        cmd = {cmd[6:0], flash_command_out_o};
        k++;
      end
      p = config_shift_clock_o;
    end
    rng("cmd_rises", 9, 9, k);
    if (k < 9)
      tally_and_finish();
    chk("cmd_byte", scp_pkg::FLASH_READ_CMD, cmd);
    chk("sel_load", 1'b0, flash_select_n_o);
    chk("clk_drive", 1'b1, config_shift_clock_oe_o);
    wait_sig(1, 1'b0, 2000, n);
    chk("init_done_act", 1'b1, init_done_oe_o);
    wait_sig(2, 1'b1, 3000, n);
    rng("act_init", 168, 400, n);
    chk("sel_idle", 1'b1, flash_select_n_o);
  endtask
  initial begin
    err_count = 0;
    total_checks = 0;
    rst_i = 1'b1;
    config_req_n_i = 1'b1;
    mode_sel_i = 2'h2;
    repeat (10) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    sc_power_up();
    sc_load(8'h01, 2, OSC_C, OSC_C + 60);
    sc_reconfig(2'h2);
    sc_load(8'h02, 2, 168, 400);
    sc_reconfig(2'h1);
    sc_active();
    sc_reconfig(2'h2);
    sc_load(8'h05, 20, 192, 400);
    tally_and_finish();
  end
endmodule
bind scp_top scp_top_monitor #(.POR_CYC(POR_CYC),
  .STATUS_CYC(STATUS_CYC), .INIT_OSC_CYC(INIT_OSC_CYC)) u_mon (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .mode_sel_i(mode_sel_i),
  .config_req_n_i(config_req_n_i), .status_n_oe_o(status_n_oe_o),
  .done_oe_o(done_oe_o), .init_done_oe_o(init_done_oe_o),
  .flash_select_n_o(flash_select_n_o),
  .config_shift_clock_oe_o(config_shift_clock_oe_o),
  .user_mode_o(user_mode_o));
